// ===== hw/vpi_pkg.sv
//**********************************************************************
// Shared constants for the vectored priority interrupt controller
//**********************************************************************
// What this block does
// - Accept sixty-four numbered request inputs
// - Map each request to sixteen levels
// - Per-source writable level control register
// - Request core only when active, enabled, unmasked
// - Acknowledge read returns unique source vector
// - Optional automatic masking of lower levels
// - Software chooses fast or normal per level
// - Per-source mask plus global mask-all
// - Combinational wake-up output from requests
// - All configuration except the two pin mode inputs through register bus slave
// - Core prefers fast over normal request
// - Fast taken when asserted and enabled
// - Normal taken only when fast negated
// - Fast entry: save status, mode, vector
// - Normal entry: save status, set disable
// - Fast and normal modes each bank one saved status and one link
// - Exception entry exits compact, link plus four
// - External top pin drives request sixty-three
// - Second external pin drives request sixty-two
// - Pending shows raw requests every cycle
// - Source mask bits reset to one
package vpi_pkg;
   localparam int          NUM_SRC      = 64;
   localparam int          NUM_LVL      = 16;
   localparam int          SRC_W        = 6;
   localparam int          LVL_W        = 4;
   localparam int          ADDR_W       = 8;
   // Register byte offsets
   localparam logic [7:0]  OFF_PEND_HI  = 8'h00;
   localparam logic [7:0]  OFF_PEND_LO  = 8'h04;
   localparam logic [7:0]  OFF_MASK_HI  = 8'h08;
   localparam logic [7:0]  OFF_MASK_LO  = 8'h0C;
   localparam logic [7:0]  OFF_CONFIG   = 8'h18;
   localparam logic [7:0]  OFF_LVL_BASE = 8'h40;
   localparam logic [7:0]  OFF_LVL_END  = 8'h7C;
   localparam logic [7:0]  OFF_ACK_NORM = 8'hEC;
   localparam logic [7:0]  OFF_ACK_FAST = 8'hF0;
   // Config register fields
   localparam int          CFG_MASK_ALL = 0;
   localparam int          CFG_AUTO_LVL = 1;
   localparam int          CFG_FASTSEL  = 16;
   localparam logic [31:0] CFG_RST      = 32'h0000_0000;
   localparam logic [63:0] MASK_RST     = 64'hFFFF_FFFF_FFFF_FFFF;
   localparam logic [7:0]  NO_VECTOR    = 8'hFF;
   localparam int          SRC_TOP      = 63;
   localparam int          SRC_SECOND   = 62;
   // Core exception entry constants
   localparam logic [4:0]  MODE_FAST    = 5'h11;
   localparam logic [4:0]  MODE_NORMAL  = 5'h12;
   localparam logic [31:0] VEC_FAST     = 32'h0000_001C;
   localparam logic [31:0] VEC_NORMAL   = 32'h0000_0018;
   localparam logic [31:0] LINK_OFFSET  = 32'h0000_0004;
   localparam logic [31:0] PC_STEP      = 32'h0000_0004;
   localparam int          MODE_LSB     = 0;
   localparam int          COMPACT_BIT  = 5;
   localparam int          FAST_DIS_BIT = 6;
   localparam int          NORM_DIS_BIT = 7;
   localparam logic [31:0] STATUS_RST   = 32'h0000_00D3;
endpackage

// ===== hw/vpi_core_if.sv
`timescale 1ns/1ps
// Link between the controller and the core's two request inputs
interface vpi_core_if;
   logic fast_req;
   logic norm_req;
   modport ctrl (output fast_req, output norm_req);
   modport core (input fast_req, input norm_req);
endinterface

// ===== hw/vpi_ctrl.sv
// The register addresses and the Avalon-MM slave port were decided locally.
`timescale 1ns/1ps
module vpi_ctrl
   import vpi_pkg::*;
#(
   parameter int N_SRC = NUM_SRC
)
(
   input  wire logic               i_clk,
   input  wire logic               i_rst_b,
   input  wire logic [N_SRC-3:0]   i_periph_req,
   input  wire logic               i_external_top_request_pin_b,
   input  wire logic               i_second_request_pin_b,
   input  wire logic               i_pin_periph_mode_top,
   input  wire logic               i_pin_periph_mode_second,
   input  wire logic [ADDR_W-1:0]  i_avs_address,
   input  wire logic               i_avs_read,
   input  wire logic               i_avs_write,
   input  wire logic [31:0]        i_avs_writedata,
   input  wire logic [3:0]         i_avs_byteenable,
   output logic [31:0]             o_avs_readdata,
   output logic                    o_avs_waitrequest,
   output logic [1:0]              o_avs_response,
   output logic                    o_wake,
   vpi_core_if.ctrl                core
);
   // Arbitration and level words are laid out for exactly 64 sources
   if (N_SRC != NUM_SRC)
   begin : g_src_check
      $error("Only 64 sources supported");
   end

   //**********************************************************************
   // Pin synchronisers
   //**********************************************************************
   logic [1:0] pin_s1;
   logic [1:0] pin_s2;
   logic [1:0] next_pin_s1;
   logic [1:0] next_pin_s2;
   always_comb
   begin
      // Raw pins go straight into the first flop; inversion comes after sync
      next_pin_s1 = {i_external_top_request_pin_b, i_second_request_pin_b};
      next_pin_s2 = pin_s1;
   end
   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         pin_s1 <= 2'h3;
         pin_s2 <= 2'h3;
      end
      else
      begin
         pin_s1 <= next_pin_s1;
         pin_s2 <= next_pin_s2;
      end
   end

   //**********************************************************************
   // Request vector and wake-up
   //**********************************************************************
   logic [63:0] req_raw;
   always_comb
   begin
      req_raw = {1'b0, 1'b0, i_periph_req};
      req_raw[SRC_TOP]    = ~pin_s2[1] & i_pin_periph_mode_top;
      req_raw[SRC_SECOND] = ~pin_s2[0] & i_pin_periph_mode_second;
   end
   // Wake path is combinational so it works with the clock stopped
   assign o_wake = (|i_periph_req)
      | (~i_external_top_request_pin_b & i_pin_periph_mode_top)
      | (~i_second_request_pin_b & i_pin_periph_mode_second);

   //**********************************************************************
   // Registers
   //**********************************************************************
   logic [63:0]      pend;
   logic [63:0]      mask;
   logic [31:0]      cfg;
   logic [LVL_W-1:0] lvl      [NUM_SRC];
   logic [LVL_W-1:0] run_lvl;
   logic             run_act;
   logic [63:0]      next_pend;
   logic [63:0]      next_mask;
   logic [31:0]      next_cfg;
   logic [LVL_W-1:0] next_lvl [NUM_SRC];
   logic [LVL_W-1:0] next_run_lvl;
   logic             next_run_act;
   logic [31:0]      next_rdata;
   logic [1:0]       next_resp;
   logic             next_wait;
   logic             next_fast;
   logic             next_norm;

   //**********************************************************************
   // Arbitration
   //**********************************************************************
   logic [63:0]      elig;
   logic             win_ok;
   logic [SRC_W-1:0] win_src;
   logic [LVL_W-1:0] win_lvl;
   always_comb
   begin
      win_ok  = 1'b0;
      win_src = '0;
      win_lvl = '0;
      for (int s = 0; s < NUM_SRC; s++)
      begin
         elig[s] = pend[s] & ~mask[s] & ~cfg[CFG_MASK_ALL]
            & (~cfg[CFG_AUTO_LVL] | ~run_act | (lvl[s] > run_lvl));
         // Ascending scan with >= lets the higher number win a tie
         if (elig[s] && (!win_ok || lvl[s] >= win_lvl))
         begin
            win_ok  = 1'b1;
            win_src = SRC_W'(s);
            win_lvl = lvl[s];
         end
      end
   end
   logic win_fast;
   assign win_fast = cfg[CFG_FASTSEL + 32'(win_lvl)];

   //**********************************************************************
   // Bus slave and state update
   //**********************************************************************
   logic        acc;
   logic        lvl_hit;
   logic [5:0]  lvl_word;
   assign acc      = (i_avs_read | i_avs_write) & o_avs_waitrequest;
   assign lvl_hit  = (i_avs_address >= OFF_LVL_BASE) && (i_avs_address <= OFF_LVL_END);
   assign lvl_word = 6'((i_avs_address - OFF_LVL_BASE) >> 2);

   always_comb
   begin
      next_pend    = req_raw;
      next_mask    = mask;
      next_cfg     = cfg;
      next_lvl     = lvl;
      next_run_lvl = run_lvl;
      next_run_act = run_act;
      next_rdata   = 32'h0000_0000;
      next_resp    = 2'h0;
      // One-cycle wait state, then answer
      next_wait    = ~acc;
      if (acc && i_avs_address[1:0] == 2'h0)
      begin
         unique case (1'b1)
            i_avs_address == OFF_PEND_HI: next_rdata = pend[63:32];
            i_avs_address == OFF_PEND_LO: next_rdata = pend[31:0];
            i_avs_address == OFF_MASK_HI:
            begin
               next_rdata = mask[63:32];
               if (i_avs_write)
                  next_mask[63:32] = i_avs_writedata;
            end
            i_avs_address == OFF_MASK_LO:
            begin
               next_rdata = mask[31:0];
               if (i_avs_write)
                  next_mask[31:0] = i_avs_writedata;
            end
            i_avs_address == OFF_CONFIG:
            begin
               next_rdata = cfg;
               if (i_avs_write)
                  next_cfg = i_avs_writedata;
            end
            lvl_hit:
               for (int b = 0; b < 4; b++)
               begin
                  next_rdata[8*b +: LVL_W] = lvl[4*lvl_word + 3 - b];
                  if (i_avs_write && i_avs_byteenable[b])
                     next_lvl[4*lvl_word + 3 - b] = i_avs_writedata[8*b +: LVL_W];
               end
            (i_avs_address == OFF_ACK_NORM) || (i_avs_address == OFF_ACK_FAST):
            begin
               if (i_avs_read && win_ok
                   && (win_fast == (i_avs_address == OFF_ACK_FAST)))
               begin
                  next_rdata   = {24'h0, 2'h0, win_src};
                  next_run_lvl = win_lvl;
                  next_run_act = 1'b1;
               end
               else if (i_avs_read)
                  next_rdata = {24'h0, NO_VECTOR};
               else
               begin
                  // Writing an acknowledge address ends the active level
                  next_run_act = 1'b0;
               end
            end
            default: next_resp = 2'h2;
         endcase
      end
      else if (acc)
         next_resp = 2'h2;
      next_fast = win_ok & win_fast;
      next_norm = win_ok & ~win_fast;
   end

   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         pend              <= 64'h0;
         mask              <= MASK_RST;
         cfg               <= CFG_RST;
         lvl               <= '{default: 4'h0};
         run_lvl           <= 4'h0;
         run_act           <= 1'b0;
         o_avs_readdata    <= 32'h0000_0000;
         o_avs_response    <= 2'h0;
         o_avs_waitrequest <= 1'b1;
         core.fast_req     <= 1'b0;
         core.norm_req     <= 1'b0;
      end
      else
      begin
         pend              <= next_pend;
         mask              <= next_mask;
         cfg               <= next_cfg;
         lvl               <= next_lvl;
         run_lvl           <= next_run_lvl;
         run_act           <= next_run_act;
         o_avs_readdata    <= next_rdata;
         o_avs_response    <= next_resp;
         o_avs_waitrequest <= next_wait;
         core.fast_req     <= next_fast;
         core.norm_req     <= next_norm;
      end
   end
endmodule

// ===== hw/vpi_core.sv
`timescale 1ns/1ps
// Behavioural exception-entry model of the core side
module vpi_core
   import vpi_pkg::*;
(
   input  wire logic        i_clk,
   input  wire logic        i_rst_b,
   input  wire logic        i_instr_done,
   input  wire logic        i_return,
   vpi_core_if.core         core,
   output logic [31:0]      o_pc,
   output logic [31:0]      o_current_status_word,
   output logic [31:0]      o_saved_status,
   output logic [31:0]      o_link,
   output logic             o_fast_bank,
   output logic             o_normal_bank
);
   logic [31:0] pc;
   logic [31:0] sts;
   logic [31:0] sv_fast;
   logic [31:0] sv_norm;
   logic [31:0] lk_fast;
   logic [31:0] lk_norm;
   logic [31:0] next_pc;
   logic [31:0] next_sts;
   logic [31:0] next_sv_fast;
   logic [31:0] next_sv_norm;
   logic [31:0] next_lk_fast;
   logic [31:0] next_lk_norm;
   logic [4:0]  mode;
   assign mode = sts[MODE_LSB +: 5];

   //**********************************************************************
   // Entry decision, once per instruction
   //**********************************************************************
   always_comb
   begin
      next_pc      = pc;
      next_sts     = sts;
      next_sv_fast = sv_fast;
      next_sv_norm = sv_norm;
      next_lk_fast = lk_fast;
      next_lk_norm = lk_norm;
      if (i_instr_done)
      begin
         next_pc = pc + PC_STEP;
         if (core.fast_req && !sts[FAST_DIS_BIT])
         begin
            next_sv_fast = sts;
            next_lk_fast = pc + LINK_OFFSET;
            next_sts[MODE_LSB +: 5] = MODE_FAST;
            next_sts[COMPACT_BIT]   = 1'b0;
            next_sts[FAST_DIS_BIT]  = 1'b1;
            next_sts[NORM_DIS_BIT]  = 1'b1;
            next_pc = VEC_FAST;
         end
         else if (!core.fast_req && core.norm_req && !sts[NORM_DIS_BIT])
         begin
            next_sv_norm = sts;
            next_lk_norm = pc + LINK_OFFSET;
            next_sts[MODE_LSB +: 5] = MODE_NORMAL;
            next_sts[COMPACT_BIT]   = 1'b0;
            next_sts[NORM_DIS_BIT]  = 1'b1;
            next_pc = VEC_NORMAL;
         end
      end
      else if (i_return && mode == MODE_FAST)
      begin
         next_sts = sv_fast;
         next_pc  = lk_fast - LINK_OFFSET;
      end
      else if (i_return && mode == MODE_NORMAL)
      begin
         next_sts = sv_norm;
         next_pc  = lk_norm - LINK_OFFSET;
      end
      else if (i_return)
      begin
         // Outside both interrupt modes a return stands in for software enabling
         next_sts[FAST_DIS_BIT] = 1'b0;
         next_sts[NORM_DIS_BIT] = 1'b0;
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         pc      <= 32'h0000_0000;
         sts     <= STATUS_RST;
         sv_fast <= 32'h0000_0000;
         sv_norm <= 32'h0000_0000;
         lk_fast <= 32'h0000_0000;
         lk_norm <= 32'h0000_0000;
         o_pc                  <= 32'h0000_0000;
         o_current_status_word <= STATUS_RST;
         o_saved_status        <= 32'h0000_0000;
         o_link                <= 32'h0000_0000;
         o_fast_bank           <= 1'b0;
         o_normal_bank         <= 1'b0;
      end
      else
      begin
         pc      <= next_pc;
         sts     <= next_sts;
         sv_fast <= next_sv_fast;
         sv_norm <= next_sv_norm;
         lk_fast <= next_lk_fast;
         lk_norm <= next_lk_norm;
         o_pc                  <= next_pc;
         o_current_status_word <= next_sts;
         o_saved_status        <= (next_sts[MODE_LSB +: 5] == MODE_FAST) ? next_sv_fast
                                                                        : next_sv_norm;
         o_link                <= (next_sts[MODE_LSB +: 5] == MODE_FAST) ? next_lk_fast
                                                                        : next_lk_norm;
         // Bank flags only follow the mode of the next status word
         o_fast_bank           <= next_sts[MODE_LSB +: 5] == MODE_FAST;
         o_normal_bank         <= next_sts[MODE_LSB +: 5] == MODE_NORMAL;
      end
   end
endmodule

// ===== testbench/vpi_asserts.sv
`timescale 1ns/1ps
module vpi_asserts
   import vpi_pkg::*;
(
   input  wire logic        i_clk,
   input  wire logic        i_rst_b,
   input  wire logic        fast_req,
   input  wire logic        norm_req,
   input  wire logic        i_instr_done,
   input  wire logic        i_return,
   input  wire logic [31:0] o_pc,
   input  wire logic [31:0] o_current_status_word,
   input  wire logic [31:0] o_saved_status,
   input  wire logic [31:0] o_link,
   input  wire logic        o_fast_bank,
   input  wire logic        o_normal_bank
);
   //***************************************************
   // Entry conditions seen by the core
   //***************************************************
   wire logic [31:0] sw      = o_current_status_word;
   wire logic        step    = i_instr_done && !i_return;
   wire logic        fast_go = step && fast_req && !sw[FAST_DIS_BIT];
   wire logic        norm_go = step && !fast_req && norm_req && !sw[NORM_DIS_BIT];
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_b);
   a_req_exclusive: assert property (!(fast_req && norm_req))
      else $error("fast and normal request high together");
   a_reset_quiet: assert property ($rose(i_rst_b) |-> !fast_req && !norm_req)
      else $error("core request high right after reset");
   a_fast_entry: assert property (fast_go |=> o_pc == VEC_FAST && sw[4:0] == MODE_FAST
      && !sw[COMPACT_BIT] && sw[FAST_DIS_BIT] && sw[NORM_DIS_BIT])
      else $error("fast entry state wrong");
   a_fast_banks: assert property (fast_go |=> o_fast_bank && !o_normal_bank)
      else $error("fast entry banking wrong");
   a_norm_entry: assert property (norm_go |=> o_pc == VEC_NORMAL && sw[4:0] == MODE_NORMAL
      && !sw[COMPACT_BIT] && sw[NORM_DIS_BIT] && sw[FAST_DIS_BIT] == $past(sw[FAST_DIS_BIT])
      && o_normal_bank && !o_fast_bank)
      else $error("normal entry state wrong");
   a_link_four: assert property (fast_go || norm_go |=> o_link == $past(o_pc) + LINK_OFFSET)
      else $error("link value wrong on entry");
   a_saved_status: assert property (fast_go || norm_go |=> o_saved_status == $past(sw))
      else $error("saved status wrong on entry");
   a_plain_step: assert property (step && !fast_go && !norm_go |=> o_pc == $past(o_pc) + PC_STEP)
      else $error("interrupt taken when not allowed");
   c_fast: cover property (fast_go);
   c_norm: cover property (norm_go);
   c_req_drop: cover property ($fell(norm_req));
endmodule

// ===== testbench/vpi_tb_top.sv
`timescale 1ns/1ps
module vpi_tb_top
   import vpi_pkg::*;
;
   logic        i_clk       = 0;
   logic        i_rst_b     = 0;
   logic [61:0] preq        = '0;
   logic [1:0]  pin_b       = 2'b11;
   logic [1:0]  pmode       = 2'b00;
   logic [7:0]  adr         = '0;
   logic        rd          = 0;
   logic        wr          = 0;
   logic [31:0] wd          = '0;
   logic [3:0]  ben         = '0;
   logic        instr_done  = 0;
   logic        ret         = 0;
   logic [31:0] rdata, pc, st, sv, lnk, q;
   logic        waitreq, wake, fb, nb;
   logic [1:0]  resp, r;
   int          n_mismatch  = 0;
   int          checks_done = 0;
   int          cycles      = 0;
   vpi_core_if cif();
   vpi_ctrl vpi_ctrl_i (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_periph_req(preq),
      .i_external_top_request_pin_b(pin_b[1]), .i_second_request_pin_b(pin_b[0]),
      .i_pin_periph_mode_top(pmode[1]), .i_pin_periph_mode_second(pmode[0]),
      .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd),
      .i_avs_byteenable(ben), .o_avs_readdata(rdata), .o_avs_waitrequest(waitreq),
      .o_avs_response(resp), .o_wake(wake), .core(cif));
   vpi_core vpi_core_i (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_instr_done(instr_done),
      .i_return(ret), .core(cif), .o_pc(pc), .o_current_status_word(st),
      .o_saved_status(sv), .o_link(lnk), .o_fast_bank(fb), .o_normal_bank(nb));
   vpi_asserts vpi_asserts_i (.i_clk(i_clk), .i_rst_b(i_rst_b), .fast_req(cif.fast_req),
      .norm_req(cif.norm_req), .i_instr_done(instr_done), .i_return(ret), .o_pc(pc),
      .o_current_status_word(st), .o_saved_status(sv), .o_link(lnk),
      .o_fast_bank(fb), .o_normal_bank(nb));
   always #12.5 i_clk = ~i_clk;
   // Whole run needs under a thousand cycles
   always @(posedge i_clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         n_mismatch++;
         report_and_stop();
      end
   end
   //***************************************************
   // Bus, compare and core helpers
   //***************************************************
   task report_and_stop();
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      checks_done++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task chkb(input logic got, input logic exp, input string what);
      checks_done++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("mismatch at %0t: %s got %b", $time, what, got);
      end
   endtask
   // Request held until waitrequest is sampled low at a rising edge
   task bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
      @(posedge i_clk);
      rd <= !w;
      wr <= w;
      adr <= a;
      wd <= d;
      ben <= be;
      do @(posedge i_clk); while (waitreq !== 1'b0);
      q = rdata;
      r = resp;
      rd <= 0;
      wr <= 0;
   endtask
   task wrw(input logic [7:0] a, input logic [31:0] d);
      bus(1, a, d, 4'hF);
   endtask
   task rdc(input logic [7:0] a, input logic [31:0] exp);
      bus(0, a, 32'h0, 4'h0);
      chk(q, exp, "read data");
   endtask
   task flags(input logic ef, input logic en);
      @(negedge i_clk);
      chkb(cif.fast_req, ef, "fast request");
      chkb(cif.norm_req, en, "normal request");
   endtask
   task cyc(input int n);
      repeat (n) @(posedge i_clk);
   endtask
   task core_take(input logic [31:0] exp_pc);
      @(posedge i_clk);
      instr_done <= 1;
      @(posedge i_clk);
      instr_done <= 0;
      @(negedge i_clk);
      chk(pc, exp_pc, "entry address");
      @(posedge i_clk);
      ret <= 1;
      @(posedge i_clk);
      ret <= 0;
   endtask
   function automatic logic [7:0] lvl_addr(input int s);
      return OFF_LVL_BASE + 8'(4 * (s / 4));
   endfunction
   function automatic logic [31:0] lvl_data(input int s, input int l);
      return 32'(l) << (8 * (3 - s % 4));
   endfunction
   task one_src(input int s, input int l, input bit f);
      logic [63:0] e;
      e = 64'h1 << s;
      bus(1, lvl_addr(s), lvl_data(s, l), 4'h1 << (3 - s % 4));
      wrw(OFF_CONFIG, 32'(f) << (CFG_FASTSEL + l));
      @(posedge i_clk);
      preq[s] <= 1;
      cyc(3);
      rdc(OFF_PEND_HI, e[63:32]);
      rdc(OFF_PEND_LO, e[31:0]);
      flags(0, 0);
      chkb(wake, 1, "wake");
      wrw(OFF_MASK_HI, ~e[63:32]);
      wrw(OFF_MASK_LO, ~e[31:0]);
      cyc(3);
      flags(f, !f);
      core_take(f ? VEC_FAST : VEC_NORMAL);
      rdc(f ? OFF_ACK_FAST : OFF_ACK_NORM, 32'(s));
      rdc(f ? OFF_ACK_NORM : OFF_ACK_FAST, {24'h0, NO_VECTOR});
      wrw(OFF_ACK_NORM, 32'h0);
      wrw(OFF_CONFIG, (32'h1 << CFG_MASK_ALL) | (32'(f) << (CFG_FASTSEL + l)));
      cyc(3);
      flags(0, 0);
      wrw(OFF_CONFIG, 32'h0);
      preq[s] <= 0;
      cyc(3);
      flags(0, 0);
      wrw(OFF_MASK_HI, 32'hFFFF_FFFF);
      wrw(OFF_MASK_LO, 32'hFFFF_FFFF);
   endtask
   //***************************************************
   // Main sequence
   //***************************************************
   initial
   begin
      void'($urandom(55716));
      repeat (4) @(posedge i_clk);
      i_rst_b <= 1;
      rdc(OFF_MASK_HI, MASK_RST[63:32]);
      rdc(OFF_MASK_LO, MASK_RST[31:0]);
      rdc(OFF_CONFIG, CFG_RST);
      rdc(OFF_PEND_LO, 32'h0);
      rdc(OFF_LVL_END, 32'h0);
      bus(0, 8'h20, 32'h0, 4'h0);
      chk(32'(r), 32'h2, "unmapped response");
      bus(0, 8'h41, 32'h0, 4'h0);
      chk(32'(r), 32'h2, "misaligned response");
      ret <= 1;
      @(posedge i_clk);
      ret <= 0;
      instr_done <= 1;
      @(posedge i_clk);
      instr_done <= 0;
      @(negedge i_clk);
      chk(pc, PC_STEP, "plain step");
      $display("test registers done");
      one_src(0, 0, 1);
      one_src(61, 15, 0);
      for (int i = 0; i < 8; i++)
         one_src($urandom % 62, $urandom % 16, 1'($urandom % 2));
      $display("test sources done");
      wrw(OFF_MASK_LO, ~32'h0010_0220);
      wrw(OFF_CONFIG, 32'h1 << CFG_AUTO_LVL);
      bus(1, lvl_addr(5), lvl_data(5, 3), 4'h4);
      bus(1, lvl_addr(9), lvl_data(9, 7), 4'h4);
      bus(1, lvl_addr(20), lvl_data(20, 7), 4'h8);
      preq <= 62'h0000_0000_0010_0220;
      cyc(3);
      rdc(OFF_ACK_NORM, 32'd20);
      preq <= 62'h0000_0000_0000_0220;
      cyc(3);
      flags(0, 0);
      wrw(OFF_ACK_NORM, 32'h0);
      cyc(3);
      flags(0, 1);
      rdc(OFF_ACK_NORM, 32'd9);
      preq <= 62'h0000_0000_0000_0020;
      cyc(3);
      flags(0, 0);
      wrw(OFF_ACK_NORM, 32'h0);
      cyc(3);
      flags(0, 1);
      @(posedge i_clk);
      preq <= '0;
      $display("test priority done");
      for (int k = 0; k < 2; k++)
      begin
         @(posedge i_clk);
         pmode[k] <= 1;
         pin_b[k] <= 0;
         @(negedge i_clk);
         chkb(wake, 1, "pin wake");
         cyc(5);
         rdc(OFF_PEND_HI, 32'h1 << (30 + k));
         pmode[k] <= 0;
         cyc(5);
         rdc(OFF_PEND_HI, 32'h0);
         chkb(wake, 0, "pin ignored");
         pin_b[k] <= 1;
      end
      $display("test pins done");
      report_and_stop();
   end
endmodule
